// [src/flash_low_setting_defs.svh]
// Offsets, field positions, encodings and timing counts of the flash power sequencer
`ifndef FLASH_LOW_SETTING_DEFS_SVH
`define FLASH_LOW_SETTING_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define OFS_GLOBAL_STATUS 8'h00
`define OFS_MODE_CONTROL 8'h04
`define OFS_RUN_CONFIG 8'h10
`define OFS_STOP_CONFIG 8'h14
`define OFS_HALT_CONFIG 8'h18
`define OFS_CHECK_SYNDROME 8'h20
`define OFS_CORE_CONTROL 8'h24
`define OFS_IRQ_STATUS 8'h28
`define OFS_IRQ_MASK 8'h2C
`define ADDR_W 8

// ----------------------------------------------------------------
// Mode control word
// ----------------------------------------------------------------
`define MODE_POS 28
`define MODE_RUN 4'h4
`define MODE_STOP 4'hA
`define MODE_HALT 4'h8
`define KEY_FIRST 16'h5AF0
`define KEY_SECOND 16'hA50F

// ----------------------------------------------------------------
// Mode configuration fields (code flash bits 17:16, data flash 19:18)
// ----------------------------------------------------------------
`define CFLA_POS 16
`define DFLA_POS 18
`define FLA_PDOWN 2'h1
`define FLA_LOWPWR 2'h2
`define FLA_NORMAL 2'h3
`define RUN_CFG_RST 32'h001F0010
`define LPM_CFG_RST 32'h00150010

// ----------------------------------------------------------------
// Global status bits
// ----------------------------------------------------------------
`define GS_MTRANS_BIT 27
`define GS_CFLA_POS 16
`define GS_DFLA_POS 18
`define GS_MODE_POS 28

// ----------------------------------------------------------------
// Machine check syndrome and core control
// ----------------------------------------------------------------
`define SYN_FETCH_ERR 32'h00090010
`define CORE_EE_BIT 0
`define CORE_ME_BIT 1
`define CORE_BIG_BIT 2

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define IRQ_DONE_BIT 0
`define IRQ_MCHK_BIT 1
`define IRQ_CSTOP_BIT 2
`define IRQ_W 3

// ----------------------------------------------------------------
// Timing: flash power settling, 2 us at 10 MHz
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define FLA_SETTLE_NS 2000
`define FLA_SETTLE_CYC ((`FLA_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8

`endif

// [src/flash_low_setting_pkg.sv]
// Types of the flash power sequencer
package flash_low_setting_pkg;
   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_SETTLE,
      SEQ_LOWPWR,
      SEQ_WAKE
   } seq_state_t;
endpackage

// [src/flash_low_setting_sequencer.sv]
// Mode entry sequencer for code and data flash power around stop and halt
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "flash_low_setting_defs.svh"


module flash_low_setting_sequencer (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [`ADDR_W-1:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic wakeup_in,
   input wire logic periph_irq_in,
   input wire logic core_irq_in,
   input wire logic fetch_in,
   output logic fetch_error_out,
   output logic periph_irq_out,
   output logic machine_check_out,
   output logic checkstop_reset_out,
   output logic code_flash_ready_out,
   output logic data_flash_ready_out,
   output logic irq_out
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   flash_low_setting_pkg::seq_state_t state_reg;
   flash_low_setting_pkg::seq_state_t state_next;
   logic [31:0] run_cfg_reg;
   logic [31:0] stop_cfg_reg;
   logic [31:0] halt_cfg_reg;
   logic [31:0] syndrome_reg;
   logic [2:0] core_ctl_reg;
   logic [`IRQ_W-1:0] irq_stat_reg;
   logic [`IRQ_W-1:0] irq_mask_reg;
   logic [`IRQ_W-1:0] irq_stat_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [3:0] cur_mode_reg;
   logic [3:0] pend_mode_reg;
   logic key_armed_reg;
   logic mtrans_reg;
   logic [1:0] cfla_flag_reg;
   logic [1:0] dfla_flag_reg;
   logic [1:0] wake_sync_reg;
   logic [2:0] pi_sync_reg;
   logic [2:0] ci_sync_reg;
   logic [2:0] fe_sync_reg;
   logic [1:0] cfla_target;
   logic [1:0] dfla_target;
   logic cfla_apply;
   logic dfla_apply;
   logic [1:0] cfla_state;
   logic [1:0] dfla_state;
   logic cfla_ready;
   logic dfla_ready;
   logic fetch_err_reg;
   logic cstop_reg;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Selects a flash field from a configuration word
   function automatic logic [1:0] fla_field(input logic [31:0] cfg, input int pos);
      fla_field = cfg[pos +: 2];
   endfunction

   // Flash is usable only in normal state and settled
   function automatic logic fla_usable(input logic [1:0] st, input logic rdy);
      fla_usable = (st == `FLA_NORMAL) && rdy;
   endfunction

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire logic wr_mode_control_register = wr_in && (addr_in == `OFS_MODE_CONTROL);
   wire logic wr_run = wr_in && (addr_in == `OFS_RUN_CONFIG);
   wire logic wr_stop = wr_in && (addr_in == `OFS_STOP_CONFIG);
   wire logic wr_halt = wr_in && (addr_in == `OFS_HALT_CONFIG);
   wire logic wr_syn = wr_in && (addr_in == `OFS_CHECK_SYNDROME);
   wire logic wr_core = wr_in && (addr_in == `OFS_CORE_CONTROL);
   wire logic wr_istat = wr_in && (addr_in == `OFS_IRQ_STATUS);
   wire logic wr_imask = wr_in && (addr_in == `OFS_IRQ_MASK);
   wire logic [3:0] req_mode = wdata_in[`MODE_POS +: 4];
   wire logic [15:0] req_key = wdata_in[15:0];
   wire logic mode_ok = (req_mode == `MODE_RUN) || (req_mode == `MODE_STOP) ||
                        (req_mode == `MODE_HALT);
   wire logic first_key = wr_mode_control_register && mode_ok && (req_key == `KEY_FIRST);
   // Second write must repeat the mode with the inverted key
   wire logic second_key = wr_mode_control_register && key_armed_reg && (req_mode == pend_mode_reg) &&
                           (req_key == `KEY_SECOND);
   wire logic start_req = second_key && !mtrans_reg;

   // ----------------------------------------------------------------
   // Configuration of the target mode
   // ----------------------------------------------------------------
   wire logic [31:0] tgt_cfg = (pend_mode_reg == `MODE_STOP) ? stop_cfg_reg :
                               (pend_mode_reg == `MODE_HALT) ? halt_cfg_reg : run_cfg_reg;
   wire logic lp_mode = (cur_mode_reg == `MODE_STOP) || (cur_mode_reg == `MODE_HALT);
   wire logic wake = wake_sync_reg[1] && lp_mode && (state_reg == flash_low_setting_pkg::SEQ_LOWPWR);
   wire logic settled = cfla_ready && dfla_ready;
   wire logic cfla_ok = fla_usable(cfla_state, cfla_ready);
   wire logic dfla_ok = fla_usable(dfla_state, dfla_ready);

   // Flash power targets: chosen mode on entry, run config on wakeup
   assign cfla_target = wake ? fla_field(run_cfg_reg, `CFLA_POS) : fla_field(tgt_cfg, `CFLA_POS);
   assign dfla_target = wake ? fla_field(run_cfg_reg, `DFLA_POS) : fla_field(tgt_cfg, `DFLA_POS);
   assign cfla_apply = start_req || wake;
   assign dfla_apply = start_req || wake;

   // ----------------------------------------------------------------
   // Flash power arrays
   // ----------------------------------------------------------------
   flash_power_cell code_cell (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .target_in(cfla_target),
      .apply_in(cfla_apply),
      .state_out(cfla_state),
      .ready_out(cfla_ready)
   );

   flash_power_cell data_cell (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .target_in(dfla_target),
      .apply_in(dfla_apply),
      .state_out(dfla_state),
      .ready_out(dfla_ready)
   );

   // ----------------------------------------------------------------
   // Sequencer state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         flash_low_setting_pkg::SEQ_IDLE: begin
            if (start_req) begin
               state_next = flash_low_setting_pkg::SEQ_SETTLE;
            end
         end
         flash_low_setting_pkg::SEQ_SETTLE: begin
            if (settled) begin
               state_next = lp_mode ? flash_low_setting_pkg::SEQ_LOWPWR : flash_low_setting_pkg::SEQ_IDLE;
            end
         end
         flash_low_setting_pkg::SEQ_LOWPWR: begin
            if (wake) begin
               state_next = flash_low_setting_pkg::SEQ_WAKE;
            end
         end
         flash_low_setting_pkg::SEQ_WAKE: begin
            if (settled) begin
               state_next = flash_low_setting_pkg::SEQ_IDLE;
            end
         end
         default: state_next = flash_low_setting_pkg::SEQ_IDLE;
      endcase
   end

   // Reaching the end of a transition
   wire logic trans_done = ((state_reg == flash_low_setting_pkg::SEQ_SETTLE) ||
                            (state_reg == flash_low_setting_pkg::SEQ_WAKE)) && settled;

   // State, mode and transition flag
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= flash_low_setting_pkg::SEQ_IDLE;
         cur_mode_reg <= `MODE_RUN;
         pend_mode_reg <= `MODE_RUN;
         key_armed_reg <= 1'b0;
         mtrans_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (wr_mode_control_register) begin
            key_armed_reg <= first_key; // Any other write disarms
         end
         if (first_key) begin
            pend_mode_reg <= req_mode;
         end
         if (start_req) begin
            cur_mode_reg <= pend_mode_reg;
            mtrans_reg <= 1'b1;
         end else if (wake) begin
            cur_mode_reg <= `MODE_RUN;
            mtrans_reg <= 1'b1;
         end else if (trans_done) begin
            mtrans_reg <= 1'b0;
         end
      end
   end

   // Status flags follow flash only at the end of a transition
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfla_flag_reg <= `FLA_NORMAL;
         dfla_flag_reg <= `FLA_NORMAL;
      end else if (trans_done) begin
         cfla_flag_reg <= cfla_state;
         dfla_flag_reg <= dfla_state;
      end
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wake_sync_reg <= 2'h0;
         pi_sync_reg <= 3'h0;
         ci_sync_reg <= 3'h0;
         fe_sync_reg <= 3'h0;
      end else begin
         wake_sync_reg <= {wake_sync_reg[0], wakeup_in};
         pi_sync_reg <= {pi_sync_reg[1:0], periph_irq_in};
         ci_sync_reg <= {ci_sync_reg[1:0], core_irq_in};
         fe_sync_reg <= {fe_sync_reg[1:0], fetch_in};
      end
   end

   // ----------------------------------------------------------------
   // Core exception logic
   // ----------------------------------------------------------------
   wire logic big_core = core_ctl_reg[`CORE_BIG_BIT];
   wire logic flash_down = !(cfla_ok && dfla_ok);
   wire logic fetch_rise = fe_sync_reg[1] && !fe_sync_reg[2];
   wire logic core_rise = ci_sync_reg[1] && !ci_sync_reg[2];
   // Fetch or core interrupt into unavailable flash is a bus error
   wire logic bus_err = (fetch_rise || core_rise) && flash_down;
   wire logic syn_set = bus_err;
   wire logic syn_pending = syndrome_reg != 32'h0;
   // Big core always takes the check; small only with enable set
   wire logic mchk_take = syn_pending && (big_core || core_ctl_reg[`CORE_ME_BIT]);
   // Small core with check disabled goes to checkstop; big core never
   wire logic cstop_set = bus_err && !big_core && !core_ctl_reg[`CORE_ME_BIT];

   // Syndrome, set wins over write-one clear
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         syndrome_reg <= 32'h0;
         fetch_err_reg <= 1'b0;
         cstop_reg <= 1'b0;
      end else begin
         syndrome_reg <= syn_set ? `SYN_FETCH_ERR : (wr_syn ? syndrome_reg & ~wdata_in :
                                                     syndrome_reg);
         fetch_err_reg <= bus_err;
         cstop_reg <= cstop_set;
      end
   end

   // Peripheral interrupt gated by enable check repeats until cleared
   assign periph_irq_out = pi_sync_reg[1] && core_ctl_reg[`CORE_EE_BIT];
   assign machine_check_out = mchk_take;
   assign checkstop_reset_out = cstop_reg;
   assign fetch_error_out = fetch_err_reg; // Core refetches until flash ready
   assign code_flash_ready_out = cfla_ok;
   assign data_flash_ready_out = dfla_ok;

   // ----------------------------------------------------------------
   // Configuration and interrupt registers
   // ----------------------------------------------------------------
   wire logic [`IRQ_W-1:0] irq_events = {cstop_set, syn_set, trans_done};
   assign irq_stat_next = irq_events |
                          (wr_istat ? irq_stat_reg & ~wdata_in[`IRQ_W-1:0] : irq_stat_reg);

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run_cfg_reg <= `RUN_CFG_RST;
         stop_cfg_reg <= `LPM_CFG_RST;
         halt_cfg_reg <= `LPM_CFG_RST;
         core_ctl_reg <= 3'h0;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         if (wr_run) run_cfg_reg <= wdata_in;
         if (wr_stop) stop_cfg_reg <= wdata_in;
         if (wr_halt) halt_cfg_reg <= wdata_in;
         if (wr_core) core_ctl_reg <= wdata_in[2:0];
         if (wr_imask) irq_mask_reg <= wdata_in[`IRQ_W-1:0];
         irq_stat_reg <= irq_stat_next;
      end
   end

   assign irq_out = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   wire logic [31:0] gs_word = ({28'h0, cur_mode_reg} << `GS_MODE_POS) |
                               ({31'h0, mtrans_reg} << `GS_MTRANS_BIT) |
                               ({30'h0, dfla_flag_reg} << `GS_DFLA_POS) |
                               ({30'h0, cfla_flag_reg} << `GS_CFLA_POS);

   always_comb begin
      case (addr_in)
         `OFS_GLOBAL_STATUS: rdata_next = gs_word;
         `OFS_MODE_CONTROL: rdata_next = {cur_mode_reg, 28'h0};
         `OFS_RUN_CONFIG: rdata_next = run_cfg_reg;
         `OFS_STOP_CONFIG: rdata_next = stop_cfg_reg;
         `OFS_HALT_CONFIG: rdata_next = halt_cfg_reg;
         `OFS_CHECK_SYNDROME: rdata_next = syndrome_reg;
         `OFS_CORE_CONTROL: rdata_next = {29'h0, core_ctl_reg};
         `OFS_IRQ_STATUS: rdata_next = {29'h0, irq_stat_reg};
         `OFS_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
         default: rdata_next = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= rd_in ? rdata_next : 32'h0;
      end
   end

   assign rdata_out = rdata_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   flag_on_start_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      start_req |=> mtrans_reg) else $error("transition flag not set on start");
   flag_clears_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      trans_done && !wake |=> !mtrans_reg) else $error("flag not cleared at end");
   bad_key_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      wr_mode_control_register && req_key != `KEY_SECOND |=> $stable(mtrans_reg) || !mtrans_reg)
      else $error("bad key started transition");
   syndrome_value_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      bus_err |=> syndrome_reg == `SYN_FETCH_ERR) else $error("wrong syndrome");
   no_cstop_big_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      big_core |=> !cstop_reg) else $error("checkstop on big core");
   mchk_big_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      big_core && syn_pending |-> machine_check_out) else $error("check not taken");
   periph_mask_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      !core_ctl_reg[`CORE_EE_BIT] |-> !periph_irq_out) else $error("irq leaked");
   wake_run_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      wake |=> cur_mode_reg == `MODE_RUN && cfla_state == $past(fla_field(run_cfg_reg, `CFLA_POS)))
      else $error("wakeup flash state wrong");
endmodule

// [src/flash_power_cell.sv]
// Model of one flash array power state with settle delay
`timescale 1ns/1ps
`include "flash_low_setting_defs.svh"

module flash_power_cell (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [1:0] target_in,
   input wire logic apply_in,
   output logic [1:0] state_out,
   output logic ready_out
);
   logic [1:0] state_reg;
   logic [1:0] state_next;
   logic [`CNT_W-1:0] cnt_reg;
   logic [`CNT_W-1:0] cnt_next;
   wire logic changing = apply_in && (target_in != state_reg);

   // Settle counter restarts whenever an applied target differs from the current state
   assign state_next = apply_in ? target_in : state_reg;
   assign cnt_next = changing ? `CNT_W'(`FLA_SETTLE_CYC) :
                     (cnt_reg != `CNT_W'h0) ? cnt_reg - `CNT_W'h1 : cnt_reg;

   // State and counter registers
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= `FLA_NORMAL;
         cnt_reg <= `CNT_W'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign state_out = state_reg;
   assign ready_out = (cnt_reg == `CNT_W'h0) && !changing;
endmodule

// [verification/tb.sv]
// Self-checking bench for the flash power mode sequencer
`timescale 1ns/1ps
`include "flash_low_setting_defs.svh"

module tb;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [`ADDR_W-1:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic wakeup = 1'b0;
   logic periph_irq = 1'b0;
   logic core_irq = 1'b0;
   logic fetch = 1'b0;
   logic [31:0] rdata;
   logic fetch_error, periph_irq_o, machine_check, checkstop, cf_ready, df_ready, irq;
   logic rd_d = 1'b0;
   logic cstop_seen = 1'b0;
   logic fe_seen = 1'b0;
   logic [63:0] exp_q[$];
   logic [31:0] rnd_state = 32'h94E3FDDE;
   logic [31:0] r;
   int num_errors = 0;
   int tests_run = 0;

   flash_low_setting_sequencer DUT (.sys_clk_in(sys_clk), .resetn_in(resetn), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .wakeup_in(wakeup),
      .periph_irq_in(periph_irq), .core_irq_in(core_irq), .fetch_in(fetch),
      .fetch_error_out(fetch_error), .periph_irq_out(periph_irq_o),
      .machine_check_out(machine_check), .checkstop_reset_out(checkstop),
      .code_flash_ready_out(cf_ready), .data_flash_ready_out(df_ready), .irq_out(irq));

   // ------------------------------------------------------------
   // Clock, read tracking and sticky checkstop monitor
   // ------------------------------------------------------------
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      rd_d <= rd;
      if (checkstop === 1'b1) cstop_seen <= 1'b1;
      if (fetch_error === 1'b1) fe_seen <= 1'b1;
   end

   // Read data checked against the oldest expectation
   always @(negedge sys_clk) begin
      if (rd_d === 1'b1) begin
         logic [63:0] e;
         e = exp_q.pop_front();
         check_word(rdata & e[63:32], e[31:0]);
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // ------------------------------------------------------------
   // Compare tasks and run end
   // ------------------------------------------------------------
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_pin(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t pin got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Register bus tasks, strobes one cycle each
   // ------------------------------------------------------------
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      exp_q.push_back({m, e & m});
   endtask

   // Keyed two-write mode request
   task automatic mode_req(input logic [3:0] m);
      bus_wr(`OFS_MODE_CONTROL, {m, 12'h000, 16'h5AF0});
      bus_wr(`OFS_MODE_CONTROL, {m, 12'h000, 16'hA50F});
   endtask

   // Watchdog sized well above the expected run of about 370 cycles
   initial begin
      #(100 * 5000);
      num_errors++;
      end_sim();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      idle(2);
      check_pin(cf_ready & df_ready, 1'b1);
      bus_rd(`OFS_GLOBAL_STATUS, 32'h080F0000, 32'h000F0000);
      bus_rd(`OFS_RUN_CONFIG, 32'hFFFFFFFF, 32'h001F0010);
      bus_rd(`OFS_STOP_CONFIG, 32'hFFFFFFFF, 32'h00150010);
      r = xs(rnd_state);
      bus_wr(8'h3C, r);
      bus_rd(8'h3C, 32'hFFFFFFFF, 32'h00000000);
      // Bad second key leaves the mode alone
      bus_wr(`OFS_RUN_CONFIG, 32'h00190010);
      bus_wr(`OFS_MODE_CONTROL, 32'h40005AF0);
      bus_wr(`OFS_MODE_CONTROL, {16'h4000, r[15:0] & 16'hFFF0});
      idle(2);
      bus_rd(`OFS_GLOBAL_STATUS, 32'h080F0000, 32'h000F0000);
      // Code power-down, data low-power, then back to normal
      mode_req(4'h4);
      bus_rd(`OFS_GLOBAL_STATUS, 32'h08000000, 32'h08000000);
      idle(30);
      bus_rd(`OFS_GLOBAL_STATUS, 32'hF80F0000, 32'h40090000);
      idle(1);
      check_pin(cf_ready | df_ready, 1'b0);
      bus_wr(`OFS_RUN_CONFIG, 32'h001F0010);
      mode_req(4'h4);
      idle(30);
      bus_rd(`OFS_GLOBAL_STATUS, 32'hF80F0000, 32'h400F0000);
      // Stop entry, wakeup into low-power run, resync to normal
      bus_wr(`OFS_RUN_CONFIG, 32'h001A0010);
      mode_req(4'hA);
      idle(30);
      bus_rd(`OFS_GLOBAL_STATUS, 32'hF80F0000, 32'hA0050000);
      wakeup <= 1'b1;
      idle(6);
      wakeup <= 1'b0;
      idle(30);
      bus_rd(`OFS_GLOBAL_STATUS, 32'hF80F0000, 32'h400A0000);
      bus_wr(`OFS_RUN_CONFIG, 32'h001F0010);
      mode_req(4'h4);
      idle(30);
      bus_rd(`OFS_GLOBAL_STATUS, 32'hF80F0000, 32'h400F0000);
      idle(1);
      check_pin(cf_ready & df_ready, 1'b1);
      // Halt entry, wakeup into normal run
      mode_req(4'h8);
      idle(30);
      bus_rd(`OFS_GLOBAL_STATUS, 32'hF80F0000, 32'h80050000);
      wakeup <= 1'b1;
      idle(6);
      wakeup <= 1'b0;
      idle(30);
      bus_rd(`OFS_GLOBAL_STATUS, 32'hF80F0000, 32'h400F0000);
      // Done interrupt: masked, unmasked, cleared
      check_pin(irq, 1'b0);
      bus_wr(`OFS_IRQ_MASK, 32'h00000001);
      idle(2);
      check_pin(irq, 1'b1);
      bus_wr(`OFS_IRQ_STATUS, 32'h00000001);
      idle(2);
      check_pin(irq, 1'b0);
      bus_rd(`OFS_IRQ_STATUS, 32'h00000001, 32'h00000000);
      // Larger core: fetch from powered-down flash
      bus_wr(`OFS_CORE_CONTROL, 32'h00000004);
      bus_wr(`OFS_RUN_CONFIG, 32'h00150010);
      mode_req(4'h4);
      idle(30);
      fetch <= 1'b1;
      idle(6);
      fetch <= 1'b0;
      check_pin(machine_check, 1'b1);
      bus_rd(`OFS_CHECK_SYNDROME, 32'hFFFFFFFF, 32'h00090010);
      idle(5);
      check_pin(machine_check, 1'b1);
      check_pin(cstop_seen, 1'b0);
      check_pin(fe_seen, 1'b1);
      bus_wr(`OFS_CHECK_SYNDROME, 32'hFFFFFFFF);
      idle(2);
      check_pin(machine_check, 1'b0);
      bus_rd(`OFS_CHECK_SYNDROME, 32'hFFFFFFFF, 32'h00000000);
      // Small core, check enable clear: checkstop reset
      bus_wr(`OFS_CORE_CONTROL, 32'h00000000);
      idle(2);
      core_irq <= 1'b1;
      idle(6);
      core_irq <= 1'b0;
      idle(2);
      check_pin(cstop_seen, 1'b1);
      // Peripheral interrupt gating by the enable bit
      repeat (4) begin
         rnd_state = xs(rnd_state);
         bus_wr(`OFS_CORE_CONTROL, {31'h0, rnd_state[0]});
         periph_irq <= rnd_state[1];
         idle(4);
         check_pin(periph_irq_o, rnd_state[0] & rnd_state[1]);
      end
      idle(3);
      end_sim();
   end
endmodule
